// ### inc/lpc_status_map.vh
// Offsets, field positions, reset values and codes of the bridge status and class-identification registers.
// Assumes configuration space is reached with a byte address and byte enables on a 32-bit dword.
`ifndef LPC_STATUS_MAP_VH
`define LPC_STATUS_MAP_VH

// ----------------------------------------------------------------
// Configuration offsets
// ----------------------------------------------------------------
`define OFS_COMMAND 8'h04
`define OFS_DEVICE_STATUS 8'h06
`define OFS_REVISION_CODE 8'h08
`define OFS_PROG_IF_CODE 8'h09
`define OFS_SUBCLASS_CODE 8'h0A
`define DWORD_STATUS 6'h01
`define DWORD_CLASS 6'h02

// ----------------------------------------------------------------
// Status fields and values
// ----------------------------------------------------------------
`define STS_PARITY_ERROR_DETECTED 15
`define STS_SYSTEM_ERROR_SIGNALED 14
`define STS_MASTER_ABORT_SENT 13
`define STS_RECEIVED_TARGET_ABORT 12
`define STS_SIGNALED_TARGET_ABORT 11
`define STS_DATA_PARITY_FLAG 8
`define STS_RESET 16'h0280
`define DEVSEL_TIMING_MEDIUM 2'h1
`define BACK_TO_BACK_CAPABLE 1'h1
`define PROG_IF_VALUE 8'h00
`define SUBCLASS_VALUE 8'h01
// Revision value is arbitrary; set per silicon step.
`define REVISION_VALUE 8'h00

// ----------------------------------------------------------------
// Command fields and error routing codes
// ----------------------------------------------------------------
`define CMD_PARITY_REACTION_ENABLE 6
`define CMD_SYSTEM_ERROR_ENABLE 8
`define ROUTE_SMI 2'h0
`define ROUTE_NMI 2'h1
`define ROUTE_IRQ 2'h2

`endif

// ### hw/sys_error_router.v
// Steers one system-error pulse onto SMI, NMI or ordinary interrupt outputs.
// Assumes the routing select is stable while a pulse arrives.
`timescale 1ns/1ps
`include "lpc_status_map.vh"

module sys_error_router (
    input wire clk_i, // Core clock.
    input wire rst_b_i, // Asynchronous reset, active low.
    input wire serr_pulse_i, // One-cycle system error event.
    input wire [1:0] route_sel_i, // Destination select.
    output reg smi_o, // SMI request pulse.
    output reg nmi_o, // NMI request pulse.
    output reg irq_o // Interrupt request pulse.
);

    // ----------------------------------------------------------------
    // Routing
    // ----------------------------------------------------------------
    // Outputs are registered so the destinations see a clean one-cycle pulse.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            smi_o <= 1'b0;
            nmi_o <= 1'b0;
            irq_o <= 1'b0;
        end
        else
        begin
            smi_o <= serr_pulse_i && (route_sel_i == `ROUTE_SMI);
            nmi_o <= serr_pulse_i && (route_sel_i == `ROUTE_NMI);
            irq_o <= serr_pulse_i && (route_sel_i == `ROUTE_IRQ);
        end
    end

endmodule // sys_error_router

// ### hw/lpc_bridge_pci_status_id.v
// Status, command-enable and class-identification registers of the bridge function.
// Assumes configuration cycles arrive pre-decoded as a dword index, byte enables and strobes.
`timescale 1ns/1ps
`include "lpc_status_map.vh"

module lpc_bridge_pci_status_id (
    input wire clk_i, // Core clock, 40 MHz.
    input wire rst_b_i, // Asynchronous reset, active low.
    input wire cfg_rd_i, // Configuration read strobe, one cycle.
    input wire cfg_wr_i, // Configuration write strobe, one cycle.
    input wire [5:0] cfg_dword_i, // Dword index of the access.
    input wire [3:0] cfg_be_i, // Byte enables.
    input wire [31:0] cfg_wdata_i, // Write data.
    output reg [31:0] cfg_rdata_o, // Read data, valid the cycle after the read.
    output reg cfg_rvalid_o, // Read data valid pulse.
    input wire perr_seen_i, // Parity error signal went active.
    input wire initiator_i, // We initiated the current cycle.
    input wire perr_data_i, // Parity error on our read or observed on our write.
    input wire serr_cause_i, // An error cause requests a system error.
    input wire master_abort_i, // Master abort on an LPC or DMA cycle.
    input wire target_abort_rx_i, // Target abort received on an LPC or DMA cycle.
    input wire target_abort_tx_i, // We target-aborted a claimed cycle.
    input wire [1:0] serr_route_i, // System error destination select.
    output wire serr_o, // System error drive request.
    output wire smi_o, // SMI request pulse.
    output wire nmi_o, // NMI request pulse.
    output wire irq_o, // Interrupt request pulse.
    output wire parity_reaction_enable_o, // Parity reaction enable level.
    output wire system_error_enable_o // System error enable level.
);

    reg [5:0] sticky_q;
    reg [5:0] sticky_d;
    reg parity_reaction_enable_q;
    reg system_error_enable_q;
    wire [15:0] status_view;
    wire [5:0] set_evt;
    wire [5:0] clr_evt;
    wire serr_pulse;
    wire wr_status;
    wire [31:0] rd_mux;

    // Packs the six sticky flags into their status positions with fixed bits.
    function [15:0] pack_status;
        input [5:0] f;
        begin
            pack_status = 16'h0000;
            pack_status[`STS_PARITY_ERROR_DETECTED] = f[5];
            pack_status[`STS_SYSTEM_ERROR_SIGNALED] = f[4];
            pack_status[`STS_MASTER_ABORT_SENT] = f[3];
            pack_status[`STS_RECEIVED_TARGET_ABORT] = f[2];
            pack_status[`STS_SIGNALED_TARGET_ABORT] = f[1];
            pack_status[10:9] = `DEVSEL_TIMING_MEDIUM;
            pack_status[`STS_DATA_PARITY_FLAG] = f[0];
            pack_status[7] = `BACK_TO_BACK_CAPABLE;
            pack_status[6:0] = 7'h00;
        end
    endfunction

    // ----------------------------------------------------------------
    // Error events
    // ----------------------------------------------------------------
    // The error output is gated by the enable so nothing is raised while disabled.
    assign serr_pulse = serr_cause_i && system_error_enable_q;
    assign serr_o = serr_pulse;
    assign set_evt[5] = perr_seen_i;
    assign set_evt[4] = serr_pulse;
    assign set_evt[3] = master_abort_i;
    assign set_evt[2] = target_abort_rx_i;
    assign set_evt[1] = target_abort_tx_i;
    assign set_evt[0] = initiator_i && perr_data_i && parity_reaction_enable_q;

    // Write-one-to-clear on the upper status byte; low byte has no writable bits.
    assign wr_status = cfg_wr_i && (cfg_dword_i == `DWORD_STATUS) && cfg_be_i[3];
    assign clr_evt = wr_status ? {cfg_wdata_i[31:27], cfg_wdata_i[24]} : 6'h00;

    // A set in the same cycle as its clear wins, so no event is lost.
    always @*
    begin
        sticky_d = (sticky_q & ~clr_evt) | set_evt;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Here only the two command enables and the sticky flags hold state; read data is registered below.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sticky_q <= 6'h00;
            parity_reaction_enable_q <= 1'b0;
            system_error_enable_q <= 1'b0;
        end
        else
        begin
            sticky_q <= sticky_d;
            if (cfg_wr_i && (cfg_dword_i == 6'h01) && cfg_be_i[0])
            begin
                parity_reaction_enable_q <= cfg_wdata_i[`CMD_PARITY_REACTION_ENABLE];
            end
            if (cfg_wr_i && (cfg_dword_i == 6'h01) && cfg_be_i[1])
            begin
                system_error_enable_q <= cfg_wdata_i[`CMD_SYSTEM_ERROR_ENABLE];
            end
        end
    end

    assign parity_reaction_enable_o = parity_reaction_enable_q;
    assign system_error_enable_o = system_error_enable_q;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    assign status_view = pack_status(sticky_q);
    // Class dword: revision, interface, subclass; byte 0Bh belongs elsewhere and reads zero here.
    assign rd_mux = (cfg_dword_i == `DWORD_STATUS) ?
        {status_view, 7'h00, system_error_enable_q, 1'b0, parity_reaction_enable_q, 6'h00} :
        (cfg_dword_i == `DWORD_CLASS) ?
        {8'h00, `SUBCLASS_VALUE, `PROG_IF_VALUE, `REVISION_VALUE} :
        32'h0000_0000;

    // Read data is registered; unenabled bytes read zero.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cfg_rdata_o <= 32'h0000_0000;
            cfg_rvalid_o <= 1'b0;
        end
        else
        begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i)
            begin
                cfg_rdata_o <= rd_mux & {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
            end
        end
    end

    // ----------------------------------------------------------------
    // System error routing
    // ----------------------------------------------------------------
    sys_error_router u_router (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .serr_pulse_i(serr_pulse),
        .route_sel_i(serr_route_i),
        .smi_o(smi_o),
        .nmi_o(nmi_o),
        .irq_o(irq_o)
    );

endmodule // lpc_bridge_pci_status_id

// ### test/lpc_status_properties.sv
// Checker for the bridge status and class registers.
// Bound to the register block; sees its ports only.
`timescale 1ns/1ps
module lpc_status_checker (
    input wire clk_i, // Core clock.
    input wire rst_b_i, // Reset, active low.
    input wire cfg_rd_i, // Read strobe.
    input wire [5:0] cfg_dword_i, // Dword index.
    input wire [3:0] cfg_be_i, // Byte enables.
    input wire [31:0] cfg_rdata_o, // Read data.
    input wire cfg_rvalid_o, // Read valid.
    input wire serr_cause_i, // Error request.
    input wire [1:0] serr_route_i, // Route select.
    input wire serr_o, // Error drive.
    input wire smi_o, // SMI pulse.
    input wire nmi_o, // NMI pulse.
    input wire irq_o, // Interrupt pulse.
    input wire system_error_enable_o // Error enable.
);
    // ----
    // Properties
    // ----
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_read_valid_timing: assert property (cfg_rvalid_o == $past(cfg_rd_i)) else $error("read valid late");
    a_serr_gate_enable: assert property (serr_o == (serr_cause_i && system_error_enable_o))
        else $error("error drive not gated");
    a_route_to_smi: assert property (serr_o && serr_route_i == 2'h0 |=> smi_o && !nmi_o && !irq_o)
        else $error("smi route wrong");
    a_route_to_nmi: assert property (serr_o && serr_route_i == 2'h1 |=> nmi_o && !smi_o && !irq_o)
        else $error("nmi route wrong");
    a_route_to_irq: assert property (serr_o && serr_route_i == 2'h2 |=> irq_o && !smi_o && !nmi_o)
        else $error("irq route wrong");
    a_no_stray_route: assert property (!serr_o |=> !(smi_o || nmi_o || irq_o))
        else $error("stray route pulse");
    a_status_fixed_bits: assert property (cfg_rd_i && cfg_dword_i == 6'h01 && cfg_be_i == 4'hF
        |=> {cfg_rdata_o[26:25], cfg_rdata_o[23:16]} == 10'h180) else $error("fixed status bits wrong");
    a_class_codes_fixed: assert property (cfg_rd_i && cfg_dword_i == 6'h02 && cfg_be_i == 4'hF
        |=> cfg_rdata_o == 32'h0001_0000) else $error("class codes wrong");
    c_status_read: cover property (cfg_rd_i && cfg_dword_i == 6'h01);
    c_serr_nmi: cover property (serr_o && serr_route_i == 2'h1);
    c_serr_drop: cover property (serr_o && serr_route_i == 2'h3);
endmodule // lpc_status_checker

// ### test/pci_cfg_host.sv
// Configuration host model issuing single reads and writes.
// Drives just after the falling edge; the block samples on the rising edge.
`timescale 1ns/1ps
module pci_cfg_host (
    input wire clk_i, // Core clock.
    input wire [31:0] rdata_i, // Read data.
    input wire rvalid_i, // Read valid.
    output logic rd_o, // Read strobe.
    output logic wr_o, // Write strobe.
    output logic [5:0] dword_o, // Dword index.
    output logic [3:0] be_o, // Byte enables.
    output logic [31:0] wdata_o // Write data.
);
    // ----
    // Access task
    // ----
    initial {rd_o, wr_o, dword_o, be_o, wdata_o} = '0;
    // The dword index and write data are inverted on release so a stale address or data never passes for a match.
    task automatic access(input bit w, input [5:0] d, input [3:0] b, input [31:0] v,
        output [31:0] q, output bit ok);
        @(negedge clk_i);
        {rd_o, wr_o} = {!w, w};
        {dword_o, be_o, wdata_o} = {d, b, v};
        @(negedge clk_i);
        {rd_o, wr_o} = 2'b00;
        {dword_o, wdata_o} = {~d, ~v};
        q = rdata_i;
        ok = w || rvalid_i;
    endtask
endmodule // pci_cfg_host

// ### test/test_lpc_bridge_pci_status_id.sv
// Self-checking bench for the bridge status and class registers.
// Uses the host model for configuration cycles and drives error events itself.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_lpc_bridge_pci_status_id;
    logic clk_i = 0;
    logic rst_b_i = 0;
    logic [6:0] ev = '0;
    logic [1:0] route = '0;
    wire rd, wr, rvalid;
    wire [5:0] dw;
    wire [3:0] be;
    wire [31:0] wd, rdata;
    wire smi, nmi, irq, parity_en, syserr_en;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] q;
    bit ok;
    logic [6:0] em [6] = '{7'h01, 7'h06, 7'h08, 7'h10, 7'h20, 7'h40};
    logic [15:0] eb [6] = '{16'h8000, 16'h0100, 16'h4000, 16'h2000, 16'h1000, 16'h0800};
    // Expected SMI, NMI and interrupt pulses for route codes 0 to 3; code 3 drops the error.
    logic [2:0] rt [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
    // ----
    // Clock, block and host
    // ----
    always #12.5 clk_i = ~clk_i;
    lpc_bridge_pci_status_id dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_rd_i(rd), .cfg_wr_i(wr),
        .cfg_dword_i(dw), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
        .perr_seen_i(ev[0]), .initiator_i(ev[1]), .perr_data_i(ev[2]), .serr_cause_i(ev[3]),
        .master_abort_i(ev[4]), .target_abort_rx_i(ev[5]), .target_abort_tx_i(ev[6]), .serr_route_i(route),
        .serr_o(), .smi_o(smi), .nmi_o(nmi), .irq_o(irq), .parity_reaction_enable_o(parity_en),
        .system_error_enable_o(syserr_en));
    pci_cfg_host u_host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .rd_o(rd), .wr_o(wr),
        .dword_o(dw), .be_o(be), .wdata_o(wd));
    task automatic chk_rd(input [5:0] d, input [3:0] b, input [31:0] e);
        u_host.access(1'b0, d, b, 32'h0000_0000, q, ok);
        `CHK({ok, q}, {1'b1, e})
    endtask
    task automatic wr_cfg(input [5:0] d, input [3:0] b, input [31:0] v);
        u_host.access(1'b1, d, b, v, q, ok);
    endtask
    task automatic pulse(input [6:0] m);
        @(negedge clk_i);
        ev = m;
        @(negedge clk_i);
        ev = '0;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // A hung handshake is cut short well past the roughly 130 cycles the tests need.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    // Tests run as sequences of configuration cycles.
    initial
    begin
        repeat (16) @(negedge clk_i);
        rst_b_i = 1;
        chk_rd(6'h01, 4'hF, 32'h0280_0000);
        chk_rd(6'h02, 4'hF, 32'h0001_0000);
        $display("test reset_values done");
        wr_cfg(6'h01, 4'hF, 32'hFFFF_FFFF);
        `CHK({parity_en, syserr_en}, 2'b11)
        chk_rd(6'h01, 4'hF, 32'h0280_0140);
        chk_rd(6'h01, 4'h3, 32'h0000_0140);
        wr_cfg(6'h02, 4'hF, 32'hFFFF_FFFF);
        chk_rd(6'h02, 4'hF, 32'h0001_0000);
        wr_cfg(6'h05, 4'hF, 32'hFFFF_FFFF);
        chk_rd(6'h05, 4'hF, 32'h0000_0000);
        $display("test write_access done");
        for (int i = 0; i < 6; i++)
        begin
            pulse(em[i]);
            chk_rd(6'h01, 4'hC, {16'h0280 | eb[i], 16'h0000});
            wr_cfg(6'h01, 4'hC, {~eb[i], 16'h0000});
            chk_rd(6'h01, 4'hC, {16'h0280 | eb[i], 16'h0000});
            wr_cfg(6'h01, 4'hC, {eb[i], 16'h0000});
            chk_rd(6'h01, 4'hC, 32'h0280_0000);
        end
        for (int r = 0; r < 4; r++)
        begin
            route = r[1:0];
            pulse(7'h08);
            `CHK({smi, nmi, irq}, rt[r])
        end
        wr_cfg(6'h01, 4'hC, 32'h4000_0000);
        wr_cfg(6'h01, 4'h3, 32'h0000_0000);
        `CHK({parity_en, syserr_en}, 2'b00)
        pulse(7'h0F);
        chk_rd(6'h01, 4'hF, 32'h8280_0000);
        $display("test error_events done");
        // A mid-run reset must drop a set flag back to its reset value.
        rst_b_i = 0;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1;
        chk_rd(6'h01, 4'hF, 32'h0280_0000);
        $display("test reset_again done");
        summarize();
    end
endmodule // test_lpc_bridge_pci_status_id
bind lpc_bridge_pci_status_id lpc_status_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .cfg_rd_i(cfg_rd_i),
    .cfg_dword_i(cfg_dword_i), .cfg_be_i(cfg_be_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .serr_cause_i(serr_cause_i), .serr_route_i(serr_route_i), .serr_o(serr_o), .smi_o(smi_o), .nmi_o(nmi_o),
    .irq_o(irq_o), .system_error_enable_o(system_error_enable_o));
